// ### inc/qcbr_pkg.sv
/*
  Shared constants and types for the quadrature count bus readout block.
  Assumes one 10 MHz clock and an asynchronous active-low clear.
*/
package qcbr_pkg;
  // Widths of the position word and of the byte bus
  localparam int QCBR_POS_W = 16;
  localparam int QCBR_BYTE_W = 8;
  // Byte select encodings
  localparam logic QCBR_SEL_HIGH = 1'h0;
  localparam logic QCBR_SEL_LOW = 1'h1;
  // Position counter reset value and wrap limits
  localparam logic [15:0] QCBR_POS_RESET = 16'h0000;
  localparam logic [15:0] QCBR_POS_MAX = 16'hFFFF;
  localparam logic [15:0] QCBR_POS_ONE = 16'h0001;
  // Field positions of the two bytes
  localparam int QCBR_HI_MSB = 15;
  localparam int QCBR_HI_LSB = 8;
  localparam int QCBR_LO_MSB = 7;
  localparam int QCBR_LO_LSB = 0;
  // Channel pair (first, second) reset value
  localparam logic [1:0] QCBR_CH_RESET = 2'h0;

  // Inhibit logic states
  typedef enum logic [1:0] {
    QCBR_INH_OPEN = 2'b00,  // Latch follows counter
    QCBR_INH_HOLD = 2'b01,  // High byte read started, latch frozen
    QCBR_INH_LOWRD = 2'b10  // Low byte read seen, wait for bus release
  } qcbr_inh_t;
endpackage : qcbr_pkg

// ### inc/qcbr_dec_if.sv
/*
  Carrier between the top module and the quadrature decoder.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/10ps
interface qcbr_dec_if;
  logic ch_first;     // Filtered first channel
  logic ch_second;    // Filtered second channel
  logic count_event;  // Registered: a transition was decoded last edge
  logic count_up;     // Registered direction of the last transition
  modport decoder (input ch_first, input ch_second, output count_event, output count_up);
  modport core (output ch_first, output ch_second, input count_event, input count_up);
endinterface : qcbr_dec_if

// ### design/qcbr_decoder.sv
/*
  4x quadrature decoder: compares the present channel pair with the last one.
  Assumes the channel inputs are already filtered and synchronous to clock.
*/
`timescale 1ns/10ps
module qcbr_decoder
  import qcbr_pkg::*;
(
  // Clock and clear
  input wire logic clock,
  input wire logic reset_n,
  // Link to the core
  qcbr_dec_if.decoder dec
);

  // Next state of the sequence going upward
  function automatic logic [1:0] qcbr_step_up(input logic [1:0] ab);
    case (ab)
      2'b10: qcbr_step_up = 2'b11;
      2'b11: qcbr_step_up = 2'b01;
      2'b01: qcbr_step_up = 2'b00;
      default: qcbr_step_up = 2'b10;
    endcase
  endfunction : qcbr_step_up

  logic [1:0] prev_ff, nxt_prev;  // Last sampled channel pair
  logic event_ff, nxt_event;      // Transition seen
  logic up_ff, nxt_up;            // Direction of that transition
  logic [1:0] cur;                // Present channel pair

  assign cur = {dec.ch_first, dec.ch_second};

  // Decode any change of state; an illegal jump still counts, keeping direction
  always_comb begin
    nxt_prev = cur;
    nxt_event = (cur != prev_ff);
    nxt_up = up_ff;
    if (cur == qcbr_step_up(prev_ff)) begin
      nxt_up = 1'b1;
    end else if (prev_ff == qcbr_step_up(cur)) begin
      nxt_up = 1'b0;
    end
  end

  // Register the decoder state
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      prev_ff <= QCBR_CH_RESET;
      event_ff <= 1'b0;
      up_ff <= 1'b1;
    end else begin
      prev_ff <= nxt_prev;
      event_ff <= nxt_event;
      up_ff <= nxt_up;
    end
  end

  assign dec.count_event = event_ff;
  assign dec.count_up = up_ff;

  a_event_on_change: assert property (@(posedge clock) disable iff (!reset_n)
    (cur != prev_ff) |=> event_ff) else $error("missed transition");
endmodule : qcbr_decoder

// ### design/qcbr_top.sv
/*
  Position counter, latch, inhibit logic, byte bus and count outputs.
  Assumes filtered channel inputs and bus controls synchronous to clock.
*/
`timescale 1ns/10ps
module qcbr_top
  import qcbr_pkg::*;
(
  // Clock and clear
  input wire logic clock,
  input wire logic reset_n,
  // Filtered quadrature channels
  input wire logic quad_channel_first,
  input wire logic quad_channel_second,
  // Bus controls from the host
  input wire logic byte_select,
  input wire logic bus_drive_enable_n,
  // Byte bus, three-state as data and enable
  output logic [QCBR_BYTE_W-1:0] byte_bus_out,
  output logic byte_bus_oe,
  // Count outputs for external counters
  output logic direction_flag,
  output logic decoder_count_pulse,
  output logic carry_borrow_pulse
);

  qcbr_dec_if dec ();  // Carrier to the decoder

  logic [QCBR_POS_W-1:0] count_ff, nxt_count;  // Position counter
  logic [QCBR_POS_W-1:0] latch_ff, nxt_latch;  // Position latch
  logic dcd_tr_ff, nxt_dcd_tr;                 // Decoder pulse, rise toggle
  logic cas_tr_ff, nxt_cas_tr;                 // Cascade pulse, rise toggle
  logic dcd_tf_ff, cas_tf_ff;                  // Fall-edge followers of toggles
  qcbr_inh_t inh_ff, nxt_inh;                  // Inhibit state
  logic wrap;                                  // Counter wraps this edge

  assign dec.ch_first = quad_channel_first;
  assign dec.ch_second = quad_channel_second;

  // Decoder instance
  qcbr_decoder u_decoder (
    .clock(clock),
    .reset_n(reset_n),
    .dec(dec)
  );

  // Wrap: up from the maximum or down from zero
  assign wrap = dec.count_event &&
    ((dec.count_up && count_ff == QCBR_POS_MAX) ||
     (!dec.count_up && count_ff == QCBR_POS_RESET));

  // Counter, latch and pulse toggles; a decoded event lands here one edge after
  // the decoder registered its direction, so direction leads each pulse
  always_comb begin
    nxt_count = count_ff;
    nxt_dcd_tr = dcd_tr_ff;
    nxt_cas_tr = cas_tr_ff;
    nxt_latch = latch_ff;
    if (dec.count_event) begin
      if (dec.count_up) begin
        nxt_count = count_ff + QCBR_POS_ONE;
      end else begin
        nxt_count = count_ff - QCBR_POS_ONE;
      end
      nxt_dcd_tr = !dcd_tr_ff;
    end
    if (wrap) begin
      nxt_cas_tr = !cas_tr_ff;
    end
    if (inh_ff == QCBR_INH_OPEN) begin
      nxt_latch = count_ff;
    end
  end

  // Rising-edge registers, cleared asynchronously
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= QCBR_POS_RESET;
      latch_ff <= QCBR_POS_RESET;
      dcd_tr_ff <= 1'b0;
      cas_tr_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      latch_ff <= nxt_latch;
      dcd_tr_ff <= nxt_dcd_tr;
      cas_tr_ff <= nxt_cas_tr;
    end
  end

  // Falling-edge followers end each pulse half a cycle after it starts
  always_ff @(negedge clock or negedge reset_n) begin
    if (!reset_n) begin
      dcd_tf_ff <= 1'b0;
      cas_tf_ff <= 1'b0;
    end else begin
      dcd_tf_ff <= dcd_tr_ff;
      cas_tf_ff <= cas_tr_ff;
    end
  end

  // Inhibit: freeze on high-byte read, release after low read once bus lets go
  always_comb begin
    case (inh_ff)
      QCBR_INH_OPEN: begin
        if (!bus_drive_enable_n && byte_select == QCBR_SEL_HIGH) begin
          nxt_inh = QCBR_INH_HOLD;
        end else begin
          nxt_inh = QCBR_INH_OPEN;
        end
      end
      QCBR_INH_HOLD: begin
        if (!bus_drive_enable_n && byte_select == QCBR_SEL_LOW) begin
          nxt_inh = QCBR_INH_LOWRD;
        end else begin
          nxt_inh = QCBR_INH_HOLD;
        end
      end
      QCBR_INH_LOWRD: begin
        if (bus_drive_enable_n) begin
          nxt_inh = QCBR_INH_OPEN;
        end else begin
          nxt_inh = QCBR_INH_LOWRD;
        end
      end
      default: nxt_inh = QCBR_INH_OPEN;
    endcase
  end

  // Inhibit samples the bus controls on the falling edge
  always_ff @(negedge clock or negedge reset_n) begin
    if (!reset_n) begin
      inh_ff <= QCBR_INH_OPEN;
    end else begin
      inh_ff <= nxt_inh;
    end
  end

  // Byte mux follows select with no clock; bus driven while enable is low
  assign byte_bus_out = (byte_select == QCBR_SEL_HIGH) ?
    latch_ff[QCBR_HI_MSB:QCBR_HI_LSB] : latch_ff[QCBR_LO_MSB:QCBR_LO_LSB];
  assign byte_bus_oe = !bus_drive_enable_n;

  // Count outputs; each pulse is the XOR of a rise toggle and its fall-edge follower
  // Direction is the decoder's own register, settled one edge before each pulse
  assign direction_flag = dec.count_up;
  assign decoder_count_pulse = dcd_tr_ff ^ dcd_tf_ff;
  assign carry_borrow_pulse = cas_tr_ff ^ cas_tf_ff;

  a_byte_mux_sel: assert property (@(posedge clock) disable iff (!reset_n)
    byte_bus_out == ((byte_select == QCBR_SEL_LOW) ?
    latch_ff[QCBR_LO_MSB:QCBR_LO_LSB] : latch_ff[QCBR_HI_MSB:QCBR_HI_LSB]))
    else $error("wrong byte on bus");
  a_bus_enable: assert property (@(posedge clock) disable iff (!reset_n)
    byte_bus_oe != bus_drive_enable_n) else $error("bus enable wrong");
  a_latch_follow: assert property (@(posedge clock) disable iff (!reset_n)
    (inh_ff == QCBR_INH_OPEN) |=> latch_ff == $past(count_ff))
    else $error("latch missed count");
  a_latch_frozen: assert property (@(posedge clock) disable iff (!reset_n)
    (inh_ff != QCBR_INH_OPEN) |=> $stable(latch_ff)) else $error("latch moved");
  a_count_step: assert property (@(posedge clock) disable iff (!reset_n)
    dec.count_event && dec.count_up |=> count_ff == $past(count_ff) + QCBR_POS_ONE)
    else $error("counter step wrong");
  a_count_down: assert property (@(posedge clock) disable iff (!reset_n)
    dec.count_event && !dec.count_up |=> count_ff == $past(count_ff) - QCBR_POS_ONE)
    else $error("counter down step wrong");
  // A pulse starts at the edge after the event is seen: its rise toggle flips there
  a_pulse_rise: assert property (@(posedge clock) disable iff (!reset_n)
    dec.count_event |=> dcd_tr_ff != $past(dcd_tr_ff)) else $error("no decoder pulse");
  // Seen just before each rising edge, both pulses have already ended at the fall
  a_pulse_fall: assert property (@(posedge clock) disable iff (!reset_n)
    !decoder_count_pulse && !carry_borrow_pulse) else $error("pulse past fall");
  // Direction shown before the pulse rose matches the way the counter stepped
  a_dir_lead: assert property (@(posedge clock) disable iff (!reset_n)
    dec.count_event |=>
    $past(direction_flag) == (count_ff == $past(count_ff) + QCBR_POS_ONE))
    else $error("direction not settled before pulse");
  a_cascade_wrap: assert property (@(posedge clock) disable iff (!reset_n)
    wrap |=> cas_tr_ff != $past(cas_tr_ff) &&
    count_ff == ($past(dec.count_up) ? QCBR_POS_RESET : QCBR_POS_MAX))
    else $error("no cascade pulse");
  a_inhibit_on: assert property (@(negedge clock) disable iff (!reset_n)
    (inh_ff == QCBR_INH_OPEN && !bus_drive_enable_n && byte_select == QCBR_SEL_HIGH)
    |=> inh_ff == QCBR_INH_HOLD) else $error("inhibit not engaged");
  a_inhibit_off: assert property (@(negedge clock) disable iff (!reset_n)
    (inh_ff == QCBR_INH_LOWRD && bus_drive_enable_n) |=> inh_ff == QCBR_INH_OPEN)
    else $error("inhibit not released");
endmodule : qcbr_top

// ### tb/qcbr_host.sv
/*
  Host model that reads the position over the byte bus.
  Assumes it shares the block's clock and drives controls after falling edges.
*/
`timescale 1ns/10ps
module qcbr_host
  import qcbr_pkg::*;
(
  // Clock
  input wire logic clock,
  // Byte bus from the block
  input wire logic [QCBR_BYTE_W-1:0] byte_bus_out,
  input wire logic byte_bus_oe,
  // Bus controls to the block
  output logic byte_select,
  output logic bus_drive_enable_n
);
  logic [QCBR_BYTE_W-1:0] last_ff = 8'h00; // Last byte seen driven
  logic [QCBR_BYTE_W-1:0] bus_level; // Wire level, inverted last byte when released
  assign bus_level = byte_bus_oe ? byte_bus_out : ~last_ff;
  // Remember the last driven byte
  always @(posedge clock) begin
    if (byte_bus_oe) begin
      last_ff <= byte_bus_out;
    end
  end
  // Idle: bus released
  initial begin
    byte_select = QCBR_SEL_LOW;
    bus_drive_enable_n = 1'h1;
  end
  // One byte: an early look just after the controls change, before any rising
  // edge, shows the mux needs no clock; the byte itself is taken at the closing
  // fall, once the inhibit logic has sampled the controls
  task automatic read_byte(input logic sel, output logic [QCBR_BYTE_W-1:0] b,
    output logic [QCBR_BYTE_W-1:0] b_early);
    @(negedge clock);
    byte_select <= sel;
    bus_drive_enable_n <= 1'h0;
    #1 b_early = bus_level;
    @(negedge clock);
    b = bus_level;
    bus_drive_enable_n <= 1'h1;
  endtask : read_byte
  // Whole position: high byte first, then low, then release is sampled
  task automatic read_pos(output logic [QCBR_POS_W-1:0] v);
    logic [QCBR_BYTE_W-1:0] e; // Early looks, not needed for the value
    read_byte(QCBR_SEL_HIGH, v[15:8], e);
    read_byte(QCBR_SEL_LOW, v[7:0], e);
    @(negedge clock);
  endtask : read_pos
endmodule : qcbr_host

// ### tb/tb_quadrature_count_bus_readout.sv
/*
  Self-checking bench for the quadrature count bus readout.
  Assumes a 10 MHz clock; channels and controls change at falling edges.
*/
`timescale 1ns/10ps
module tb_quadrature_count_bus_readout
  import qcbr_pkg::*;
;
  logic clock, reset_n, quad_channel_first, quad_channel_second;
  logic byte_select, bus_drive_enable_n, byte_bus_oe;
  logic [7:0] byte_bus_out;
  logic direction_flag, decoder_count_pulse, carry_borrow_pulse;
  int n_mismatch, compares, n_dec, n_cas, ph;
  logic [15:0] cnt, v; // Expected counter, read value
  logic [7:0] hi, lo, hi_e, lo_e; // Bytes at the closing fall and just after select
  logic [1:0] seq [4] = '{2'h2, 2'h3, 2'h1, 2'h0}; // Up order of the pair
  qcbr_top dut (.clock(clock), .reset_n(reset_n), .quad_channel_first(quad_channel_first),
    .quad_channel_second(quad_channel_second), .byte_select(byte_select),
    .bus_drive_enable_n(bus_drive_enable_n), .byte_bus_out(byte_bus_out),
    .byte_bus_oe(byte_bus_oe), .direction_flag(direction_flag),
    .decoder_count_pulse(decoder_count_pulse), .carry_borrow_pulse(carry_borrow_pulse));
  qcbr_host host (.clock(clock), .byte_bus_out(byte_bus_out), .byte_bus_oe(byte_bus_oe),
    .byte_select(byte_select), .bus_drive_enable_n(bus_drive_enable_n));
  // 100 ns clock
  initial clock = 1'h0;
  always #50 clock = ~clock;
  // Pulse counters
  always @(posedge decoder_count_pulse) n_dec++;
  always @(posedge carry_borrow_pulse) n_cas++;
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Both pulses must be low just after every falling edge
  always @(negedge clock) begin
    #1 if (reset_n === 1'h1) check({14'h0, decoder_count_pulse, carry_borrow_pulse}, 16'h0);
  end
  // Run n quadrature steps one way, then let the pipeline settle
  task automatic run(input int n, input logic up);
    repeat (n) begin
      @(negedge clock);
      ph = up ? (ph + 1) % 4 : (ph + 3) % 4;
      {quad_channel_first, quad_channel_second} <= seq[ph];
      cnt = up ? cnt + 16'h0001 : cnt - 16'h0001;
    end
    repeat (3) @(negedge clock);
  endtask : run
  // Values straight after clear
  task automatic t_reset;
    check({15'h0, byte_bus_oe}, 16'h0);
    check({15'h0, direction_flag}, 16'h1);
    host.read_pos(v);
    check(v, 16'h0000);
  endtask : t_reset
  // Down through zero, then up through FFFF
  task automatic t_wrap;
    n_dec = 0;
    n_cas = 0;
    run(3, 1'h0);
    check({15'h0, direction_flag}, 16'h0);
    check(16'(n_cas), 16'h0001);
    host.read_pos(v);
    check(v, cnt);
    run(5, 1'h1);
    check({15'h0, direction_flag}, 16'h1);
    check(16'(n_cas), 16'h0002);
    check(16'(n_dec), 16'h0008);
    host.read_pos(v);
    check(v, cnt);
  endtask : t_wrap
  // Counts during a read do not reach the latch until the low byte ends it
  task automatic t_freeze;
    v = cnt;
    host.read_byte(QCBR_SEL_HIGH, hi, hi_e);
    check({8'h00, hi_e}, {8'h00, hi});
    n_dec = 0;
    run(4, 1'h1);
    check(16'(n_dec), 16'h0004);
    host.read_byte(QCBR_SEL_LOW, lo, lo_e);
    check({8'h00, lo_e}, {8'h00, lo});
    check({hi, lo}, v);
    repeat (2) @(negedge clock);
    host.read_pos(v);
    check(v, cnt);
  endtask : t_freeze
  // Clear in mid-run zeroes counter and latch
  task automatic t_clear;
    @(negedge clock);
    reset_n <= 1'h0;
    {quad_channel_first, quad_channel_second} <= 2'h0;
    @(negedge clock);
    reset_n <= 1'h1;
    ph = 3;
    cnt = 16'h0000;
    host.read_pos(v);
    check(v, 16'h0000);
    check({15'h0, direction_flag}, 16'h1);
  endtask : t_clear
  // A two-step jump still counts once, in the last direction
  task automatic t_jump;
    n_dec = 0;
    @(negedge clock);
    ph = (ph + 2) % 4;
    {quad_channel_first, quad_channel_second} <= seq[ph];
    cnt = cnt + 16'h0001;
    repeat (3) @(negedge clock);
    check(16'(n_dec), 16'h0001);
    check({15'h0, direction_flag}, 16'h0001);
    host.read_pos(v);
    check(v, cnt);
  endtask : t_jump
  task automatic summarize;
    $display("mismatches %0d comparisons %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // Main sequence
  initial begin
    reset_n = 1'h0;
    quad_channel_first = 1'h0;
    quad_channel_second = 1'h0;
    n_mismatch = 0;
    compares = 0;
    ph = 3;
    cnt = 16'h0000;
    repeat (3) @(negedge clock);
    reset_n <= 1'h1;
    t_reset();
    t_wrap();
    t_freeze();
    t_clear();
    run(2, 1'h1);
    host.read_pos(v);
    check(v, cnt);
    t_jump();
    summarize();
  end
  // Hang guard
  initial begin
    #2000000;
    n_mismatch++;
    summarize();
  end
endmodule : tb_quadrature_count_bus_readout
